// ===== clp_pkg.sv
package clp_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ENC_IDX_W = 6;
  localparam int unsigned ENC_DEPTH = 64;
  localparam int unsigned LOCK_BITS = 3;

  // ----------------------------------------------------------------
  // Reset and fill values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] ENC_ERASED = 8'hff;
  localparam logic [DATA_W-1:0] VERIFY_BLANK = 8'hff;
  localparam logic [DATA_W-1:0] LOOKUP_BLANK = 8'hff;
  localparam logic [LOCK_BITS-1:0] LOCK_NONE = 3'h0;

  // Lock bit positions within lock_cell_i (1 = programmed)
  localparam int unsigned LB_ONE_POS = 0;
  localparam int unsigned LB_TWO_POS = 1;
  localparam int unsigned LB_THREE_POS = 2;

  // Lock patterns that name a level
  localparam logic [LOCK_BITS-1:0] PAT_L1 = 3'h0;
  localparam logic [LOCK_BITS-1:0] PAT_L2 = 3'h1;
  localparam logic [LOCK_BITS-1:0] PAT_L3 = 3'h3;
  localparam logic [LOCK_BITS-1:0] PAT_L4 = 3'h7;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LVL_1 = 2'b00,
    LVL_2 = 2'b01,
    LVL_3 = 2'b10,
    LVL_4 = 2'b11
  } clp_level_t;

  typedef enum logic [2:0] {
    PSEL_CODE = 3'b000,
    PSEL_ENC = 3'b001,
    PSEL_LOCK_ONE = 3'b010,
    PSEL_LOCK_TWO = 3'b011,
    PSEL_LOCK_THREE = 3'b100
  } clp_psel_t;

  typedef enum logic [0:0] {
    ST_INIT = 1'b0,
    ST_RUN = 1'b1
  } clp_state_t;

endpackage

// ===== clp_enc_if.sv
`timescale 1ns/1ns
`default_nettype none

interface clp_enc_if;
  import clp_pkg::*;
  logic wr_en;
  logic [ENC_IDX_W-1:0] wr_idx;
  logic [DATA_W-1:0] wr_data;
  logic clr;
  logic [ENC_IDX_W-1:0] rd_idx;
  logic [DATA_W-1:0] rd_data;

  modport ctl (output wr_en, output wr_idx, output wr_data, output clr, output rd_idx, input rd_data);
  modport arr (input wr_en, input wr_idx, input wr_data, input clr, input rd_idx, output rd_data);
endinterface

`default_nettype wire

// ===== clp_enc_array.sv
`timescale 1ns/1ns
`default_nettype none

module clp_enc_array
  import clp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Array access
  clp_enc_if.arr enc
);

  typedef struct packed {
    logic [ENC_DEPTH-1:0][DATA_W-1:0] mem;
  } clp_enc_st_t;

  clp_enc_st_t st_ff;
  clp_enc_st_t nxt_st;

  // ----------------------------------------------------------------
  // Storage: programming only clears bits, erase restores all ones
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    for (int i = 0; i < ENC_DEPTH; i++) begin
      if (enc.clr) begin
        nxt_st.mem[i] = ENC_ERASED;
      end else if (enc.wr_en && (enc.wr_idx == ENC_IDX_W'(i))) begin
        nxt_st.mem[i] = st_ff.mem[i] & enc.wr_data;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= {ENC_DEPTH{ENC_ERASED}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign enc.rd_data = st_ff.mem[enc.rd_idx];

endmodule

`default_nettype wire

// ===== clp_lock.sv
`timescale 1ns/1ns
`default_nettype none

module clp_lock
  import clp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Lock cells
  input wire logic [LOCK_BITS-1:0] lock_cell_i,
  output logic [LOCK_BITS-1:0] lock_program_pulse_o,
  // Programmer side
  input wire logic [2:0] program_pulse_sel_i,
  input wire logic program_pulse_i,
  input wire logic erase_i,
  input wire logic verify_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0] verify_data_o,
  output logic verify_valid_o,
  // Code memory side
  input wire logic [DATA_W-1:0] code_byte_i,
  output logic code_wr_o,
  output logic [ADDR_W-1:0] code_wr_addr_o,
  output logic [DATA_W-1:0] code_wr_data_o,
  output logic code_erase_o,
  // Fetch side
  input wire logic lookup_req_i,
  input wire logic lookup_from_ext_i,
  input wire logic [DATA_W-1:0] lookup_code_i,
  output logic [DATA_W-1:0] lookup_data_o,
  output logic lookup_valid_o,
  input wire logic external_access_select_i,
  output logic external_access_select_o,
  output logic ext_exec_block_o,
  output logic [1:0] level_o
);

  typedef struct packed {
    clp_state_t state;
    clp_level_t level;
    logic pulse_d;
    logic ext_sel;
    logic [LOCK_BITS-1:0] lock_program_pulse;
    logic [DATA_W-1:0] verify_data;
    logic verify_valid;
    logic code_wr;
    logic [ADDR_W-1:0] code_wr_addr;
    logic [DATA_W-1:0] code_wr_data;
    logic code_erase;
    logic [DATA_W-1:0] lookup_data;
    logic lookup_valid;
    logic ext_block;
  } clp_st_t;

  clp_st_t st_ff;
  clp_st_t nxt_st;
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic pulse_edge;
  logic locked_program_pulse;
  logic locked_verify;
  clp_level_t cell_level;
  clp_enc_if enc ();

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  // ----------------------------------------------------------------
  // Level decode
  // ----------------------------------------------------------------
  always_comb begin
    case (lock_cell_i)
      PAT_L1: cell_level = LVL_1;
      PAT_L2: cell_level = LVL_2;
      PAT_L3: cell_level = LVL_3;
      PAT_L4: cell_level = LVL_4;
      default: cell_level = LVL_4;
    endcase
  end

  assign pulse_edge = program_pulse_i && !st_ff.pulse_d;
  assign locked_program_pulse = (st_ff.level != LVL_1);
  assign locked_verify = (st_ff.level == LVL_3) || (st_ff.level == LVL_4);

  // ----------------------------------------------------------------
  // Encryption array
  // ----------------------------------------------------------------
  assign enc.rd_idx = addr_i[ENC_IDX_W-1:0];
  assign enc.clr = erase_i;
  assign enc.wr_en = pulse_edge && !erase_i && (st_ff.state == ST_RUN) && !locked_program_pulse
                     && (program_pulse_sel_i == PSEL_ENC);
  assign enc.wr_idx = addr_i[ENC_IDX_W-1:0];
  assign enc.wr_data = data_i;

  clp_enc_array u_enc (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .enc(enc)
  );

  // ----------------------------------------------------------------
  // Control
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pulse_d = program_pulse_i;
    nxt_st.lock_program_pulse = LOCK_NONE;
    nxt_st.code_wr = 1'b0;
    nxt_st.code_erase = 1'b0;
    nxt_st.verify_valid = 1'b0;
    nxt_st.verify_data = VERIFY_BLANK;
    nxt_st.lookup_valid = 1'b0;
    nxt_st.lookup_data = LOOKUP_BLANK;
    case (st_ff.state)
      ST_INIT: begin
        nxt_st.level = cell_level;
        nxt_st.ext_sel = external_access_select_i;
        nxt_st.ext_block = (cell_level == LVL_4);
        nxt_st.state = ST_RUN;
      end
      ST_RUN: begin
        if (!locked_program_pulse) begin
          nxt_st.ext_sel = external_access_select_i;
        end
        if (erase_i) begin
          nxt_st.level = LVL_1;
          nxt_st.ext_block = 1'b0;
          nxt_st.code_erase = 1'b1;
        end else if (pulse_edge) begin
          case (program_pulse_sel_i)
            PSEL_CODE: begin
              nxt_st.code_wr = !locked_program_pulse;
              nxt_st.code_wr_addr = addr_i;
              nxt_st.code_wr_data = data_i;
            end
            PSEL_LOCK_ONE: nxt_st.lock_program_pulse[LB_ONE_POS] = 1'b1;
            PSEL_LOCK_TWO: nxt_st.lock_program_pulse[LB_TWO_POS] = 1'b1;
            PSEL_LOCK_THREE: nxt_st.lock_program_pulse[LB_THREE_POS] = 1'b1;
            default: nxt_st.lock_program_pulse = LOCK_NONE;
          endcase
        end
        if (verify_i && !locked_verify) begin
          nxt_st.verify_valid = 1'b1;
          nxt_st.verify_data = ~(code_byte_i ^ enc.rd_data);
        end
        if (lookup_req_i && !(lookup_from_ext_i && locked_program_pulse)) begin
          nxt_st.lookup_valid = 1'b1;
          nxt_st.lookup_data = lookup_code_i;
        end
      end
      default: nxt_st.state = ST_INIT;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{state: ST_INIT, level: LVL_1, pulse_d: 1'b0, ext_sel: 1'b0, lock_program_pulse: LOCK_NONE,
                 verify_data: VERIFY_BLANK, verify_valid: 1'b0, code_wr: 1'b0, code_wr_addr: '0,
                 code_wr_data: '0, code_erase: 1'b0, lookup_data: LOOKUP_BLANK, lookup_valid: 1'b0,
                 ext_block: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lock_program_pulse_o = st_ff.lock_program_pulse;
  assign verify_data_o = st_ff.verify_data;
  assign verify_valid_o = st_ff.verify_valid;
  assign code_wr_o = st_ff.code_wr;
  assign code_wr_addr_o = st_ff.code_wr_addr;
  assign code_wr_data_o = st_ff.code_wr_data;
  assign code_erase_o = st_ff.code_erase;
  assign lookup_data_o = st_ff.lookup_data;
  assign lookup_valid_o = st_ff.lookup_valid;
  assign external_access_select_o = st_ff.ext_sel;
  assign ext_exec_block_o = st_ff.ext_block;
  assign level_o = st_ff.level;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);

  sequence seq_run_quiet;
    (st_ff.state == ST_RUN) && !erase_i;
  endsequence

  sequence seq_code_pulse;
    seq_run_quiet ##0 pulse_edge && (program_pulse_sel_i == PSEL_CODE);
  endsequence

  chk_open_verify_xnor: assert property (
    seq_run_quiet ##0 (verify_i && st_ff.level == LVL_1)
    |=> verify_valid_o && (verify_data_o == ~($past(code_byte_i) ^ $past(enc.rd_data))))
    else $error("verify data at level 1 is not the encrypted code byte");

  chk_lookup_ext_block: assert property (
    seq_run_quiet ##0 (lookup_req_i && lookup_from_ext_i && st_ff.level != LVL_1)
    |=> !lookup_valid_o && (lookup_data_o == LOOKUP_BLANK))
    else $error("external lookup returned internal code while locked");

  chk_ext_sel_hold: assert property (
    (st_ff.state == ST_RUN) && (st_ff.level != LVL_1) && !erase_i |=> $stable(external_access_select_o))
    else $error("latched external access select changed while locked");

  chk_program_pulse_refused: assert property (
    seq_code_pulse ##0 (st_ff.level != LVL_1) |=> !code_wr_o)
    else $error("code write issued while programming is locked");

  chk_program_pulse_open_write: assert property (
    seq_code_pulse ##0 (st_ff.level == LVL_1) |=> code_wr_o && (code_wr_addr_o == $past(addr_i)))
    else $error("code write missing at level 1");

  chk_verify_disabled: assert property (
    verify_i && (st_ff.level == LVL_3 || st_ff.level == LVL_4) |=> !verify_valid_o ##1 1)
    else $error("verify readout given at level 3 or 4");

  chk_ext_exec_block: assert property (
    (st_ff.state == ST_RUN) |-> (ext_exec_block_o == (st_ff.level == LVL_4)))
    else $error("external execution block does not follow level 4");

  chk_enc_select_xnor: assert property (
    seq_run_quiet ##0 (verify_i && st_ff.level == LVL_2)
    |=> verify_data_o == ~($past(code_byte_i) ^ u_enc.st_ff.mem[$past(addr_i[ENC_IDX_W-1:0])]))
    else $error("verify byte not combined with the addressed encryption byte");

  chk_erase_clears: assert property (
    erase_i |=> (level_o == LVL_1) && code_erase_o && (enc.rd_data == ENC_ERASED))
    else $error("erase did not return to level 1 with a blank array");

  chk_level_decode: assert property (
    (st_ff.state == ST_INIT) |=> (level_o == $past(cell_level)) ##1 (st_ff.state == ST_RUN))
    else $error("level not decoded from the lock cells at reset release");

  chk_level_steady: assert property (
    (st_ff.state == ST_RUN) && !erase_i |=> $stable(level_o))
    else $error("level changed without reset or erase");

endmodule

`default_nettype wire

// ===== clp_program_pulse_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Lock cells and code memory seen by the protection logic
// ----------------------------------------------------------------
module clp_program_pulse_model
  import clp_pkg::*;
(
  // Clock
  input wire logic sys_clk_i,
  // Requests from the protection logic
  input wire logic [LOCK_BITS-1:0] lock_program_pulse_i,
  input wire logic code_wr_i,
  input wire logic [ADDR_W-1:0] code_wr_addr_i,
  input wire logic [DATA_W-1:0] code_wr_data_i,
  input wire logic code_erase_i,
  input wire logic [ADDR_W-1:0] addr_i,
  // Stored state
  output logic [LOCK_BITS-1:0] lock_cell_o,
  output logic [DATA_W-1:0] code_byte_o
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  initial begin
    lock_cell_o = LOCK_NONE;
    for (int i = 0; i < (1<<ADDR_W); i++) mem[i] = 8'hff;
  end

  // Lock cells only ever gain ones and code bytes only ever lose ones until an erase
  always @(posedge sys_clk_i) begin
    if (code_erase_i) begin
      lock_cell_o <= LOCK_NONE;
      for (int i = 0; i < (1<<ADDR_W); i++) mem[i] <= 8'hff;
    end else begin
      lock_cell_o <= lock_cell_o | lock_program_pulse_i;
      if (code_wr_i) mem[code_wr_addr_i] <= mem[code_wr_addr_i] & code_wr_data_i;
    end
  end

  assign code_byte_o = mem[addr_i];
endmodule

`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;
  import clp_pkg::*;
  logic sys_clk_i = 1'b0, rstn_i = 1'b0, program_pulse_i = 1'b0, erase_i = 1'b0, verify_i = 1'b0;
  logic lookup_req_i = 1'b0, lookup_from_ext_i = 1'b0, external_access_select_i = 1'b0;
  logic [2:0] program_pulse_sel_i = 3'h0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] data_i = 8'h00, lookup_code_i = 8'h00, code_byte_i, verify_data_o, lookup_data_o;
  logic [LOCK_BITS-1:0] lock_cell_i, lock_program_pulse_o;
  logic verify_valid_o, code_wr_o, code_erase_o, lookup_valid_o, external_access_select_o, ext_exec_block_o;
  logic [ADDR_W-1:0] code_wr_addr_o;
  logic [DATA_W-1:0] code_wr_data_o;
  logic [1:0] level_o;
  logic [DATA_W-1:0] code_m [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] enc_m [0:ENC_DEPTH-1];
  logic [ADDR_W-1:0] addrs [0:3];
  logic [8:0] notes [$];
  logic [31:0] seed = 32'h79a4;
  logic was_verify = 1'b0;
  int mismatches = 0, tests_run = 0, wr_cnt = 0, wr_ref;

  always #4 sys_clk_i = ~sys_clk_i;

  clp_lock u_clp_lock (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .lock_cell_i(lock_cell_i),
    .lock_program_pulse_o(lock_program_pulse_o), .program_pulse_sel_i(program_pulse_sel_i), .program_pulse_i(program_pulse_i),
    .erase_i(erase_i), .verify_i(verify_i), .addr_i(addr_i), .data_i(data_i),
    .verify_data_o(verify_data_o), .verify_valid_o(verify_valid_o), .code_byte_i(code_byte_i),
    .code_wr_o(code_wr_o), .code_wr_addr_o(code_wr_addr_o), .code_wr_data_o(code_wr_data_o),
    .code_erase_o(code_erase_o), .lookup_req_i(lookup_req_i), .lookup_from_ext_i(lookup_from_ext_i),
    .lookup_code_i(lookup_code_i), .lookup_data_o(lookup_data_o), .lookup_valid_o(lookup_valid_o),
    .external_access_select_i(external_access_select_i),
    .external_access_select_o(external_access_select_o), .ext_exec_block_o(ext_exec_block_o),
    .level_o(level_o));

  clp_program_pulse_model u_clp_program_pulse_model (.sys_clk_i(sys_clk_i), .lock_program_pulse_i(lock_program_pulse_o), .code_wr_i(code_wr_o),
    .code_wr_addr_i(code_wr_addr_o), .code_wr_data_i(code_wr_data_o), .code_erase_i(code_erase_o),
    .addr_i(addr_i), .lock_cell_o(lock_cell_i), .code_byte_o(code_byte_i));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("compares %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic do_reset(input logic pin);
    // Array flops lose their contents on reset
    for (int i = 0; i < ENC_DEPTH; i++) enc_m[i] = ENC_ERASED;
    external_access_select_i <= pin;
    rstn_i <= 1'b0;
    repeat (12) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
  endtask

  task automatic program_pulse(input logic [2:0] sel, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
    @(posedge sys_clk_i);
    program_pulse_sel_i <= sel;
    addr_i <= ad;
    data_i <= d;
    program_pulse_i <= 1'b1;
    @(posedge sys_clk_i);
    program_pulse_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
  endtask

  task automatic verify(input logic [ADDR_W-1:0] ad, input logic ok);
    @(posedge sys_clk_i);
    verify_i <= 1'b1;
    addr_i <= ad;
    notes.push_back(ok ? {1'b1, ~(code_m[ad] ^ enc_m[ad[5:0]])} : {1'b0, VERIFY_BLANK});
    @(posedge sys_clk_i);
    verify_i <= 1'b0;
  endtask

  task automatic lookup(input logic ext, input logic ok);
    @(posedge sys_clk_i);
    seed = lfsr(seed);
    lookup_req_i <= 1'b1;
    lookup_from_ext_i <= ext;
    lookup_code_i <= seed[7:0];
    notes.push_back(ok ? {1'b1, seed[7:0]} : {1'b0, LOOKUP_BLANK});
    @(posedge sys_clk_i);
    lookup_req_i <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (code_wr_o) wr_cnt++;
    if (verify_i || lookup_req_i) begin
      was_verify = verify_i;
      #1;
      if (was_verify) chk(16'({verify_valid_o, verify_data_o}), 16'(notes.pop_front()));
      else chk(16'({lookup_valid_o, lookup_data_o}), 16'(notes.pop_front()));
    end
  end

  initial begin
    #200000;
    mismatches++;
    test_done();
  end

  initial begin
    for (int i = 0; i < (1<<ADDR_W); i++) code_m[i] = 8'hff;
    for (int i = 0; i < ENC_DEPTH; i++) enc_m[i] = ENC_ERASED;
    do_reset(1'b0);
    chk(level_o, LVL_1);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      addrs[i] = seed[13:0];
      program_pulse(PSEL_CODE, seed[13:0], seed[21:14]);
      code_m[seed[13:0]] &= seed[21:14];
    end
    chk(16'(wr_cnt), 16'h0004);
    program_pulse(PSEL_ENC, addrs[0], 8'h5a);
    enc_m[addrs[0][5:0]] &= 8'h5a;
    for (int i = 0; i < 4; i++) verify(addrs[i], 1'b1);
    verify(addrs[0] ^ 14'h0040, 1'b1);
    lookup(1'b1, 1'b1);
    external_access_select_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    chk(external_access_select_o, 1'b1);
    $display("level one test done");
    program_pulse(PSEL_LOCK_ONE, '0, 8'h00);
    chk(level_o, LVL_1);
    do_reset(1'b1);
    chk(level_o, LVL_2);
    external_access_select_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    chk(external_access_select_o, 1'b1);
    lookup(1'b1, 1'b0);
    lookup(1'b0, 1'b1);
    wr_ref = wr_cnt;
    program_pulse(PSEL_CODE, addrs[0], 8'h00);
    program_pulse(PSEL_ENC, addrs[0], 8'h00);
    chk(16'(wr_cnt), 16'(wr_ref));
    verify(addrs[0], 1'b1);
    $display("level two test done");
    program_pulse(PSEL_LOCK_TWO, '0, 8'h00);
    do_reset(1'b0);
    chk(level_o, LVL_3);
    verify(addrs[1], 1'b0);
    lookup(1'b1, 1'b0);
    $display("level three test done");
    program_pulse(PSEL_LOCK_THREE, '0, 8'h00);
    do_reset(1'b0);
    chk({level_o, ext_exec_block_o}, {LVL_4, 1'b1});
    verify(addrs[2], 1'b0);
    $display("level four test done");
    @(posedge sys_clk_i);
    erase_i <= 1'b1;
    @(posedge sys_clk_i);
    erase_i <= 1'b0;
    #1;
    chk({level_o, ext_exec_block_o, code_erase_o}, {LVL_1, 1'b0, 1'b1});
    for (int i = 0; i < (1<<ADDR_W); i++) code_m[i] = 8'hff;
    for (int i = 0; i < ENC_DEPTH; i++) enc_m[i] = ENC_ERASED;
    verify(addrs[0], 1'b1);
    repeat (3) @(posedge sys_clk_i);
    $display("erase test done");
    test_done();
  end
endmodule

`default_nettype wire
